/* baud_gen_pkg.sv */
/*
 baud_gen_pkg: register map, field layout, reset values and shared
 types of the serial baud rate generator.
 assumes a 32-bit apb slave on a 10 mhz bus clock.
*/
`default_nettype none
package baud_gen_pkg;

	localparam int unsigned div_width = 13;
	localparam int unsigned div_high_width = 5;
	localparam int unsigned oversample = 16;
	localparam int unsigned os_width = 4;

	// byte addresses, one aligned word each
	localparam logic [7:0] baud_divisor_high_reg_off = 8'h00;
	localparam logic [7:0] baud_divisor_low_reg_off = 8'h04;
	localparam logic [7:0] control_two_reg_off = 8'h08;
	localparam logic [7:0] irq_status_off = 8'h0c;
	localparam logic [7:0] irq_mask_off = 8'h10;
	localparam logic [7:0] gen_status_off = 8'h14;

	// high register fields
	localparam int unsigned break_irq_en_bit = 7;
	localparam int unsigned edge_irq_en_bit = 6;
	localparam int unsigned unused_high_bit = 5;
	localparam int unsigned high_div_msb = 4;

	// control two fields
	localparam int unsigned te_bit = 3;
	localparam int unsigned re_bit = 2;

	// status / mask fields
	localparam int unsigned st_break_bit = 0;
	localparam int unsigned st_edge_bit = 1;
	localparam int unsigned st_tick_bit = 2;
	localparam int unsigned st_width = 3;

	// gen status fields
	localparam int unsigned gs_active_bit = 0;

	localparam logic [7:0] high_reset = 8'h00;
	localparam logic [7:0] low_reset = 8'h04;
	localparam logic [st_width-1:0] mask_reset = 3'h0;

	typedef struct packed {
		logic break_detect_irq_enable;
		logic rx_edge_irq_enable;
		logic [div_high_width-1:0] div_high;
	} high_fields_t;

	typedef struct packed {
		logic receiver_enable;
		logic transmitter_enable;
	} enables_t;

	typedef enum logic [1:0] {
		gen_idle = 2'b00,
		gen_run = 2'b01,
		gen_off = 2'b10
	} gen_state_t;

endpackage
`default_nettype wire

/* baud_divider.sv */
/*
 baud_divider: modulo counter giving one-cycle enable pulses.
 assumes a divisor held stable by its owner and a synchronous enable.
*/
`timescale 1ns/100ps
`default_nettype none
module baud_divider #(
	parameter int unsigned width = 13
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic run,
	input wire logic [width-1:0] modulo,
	output logic tick
);
	if (width < 1) begin : width_check
		$error("baud_divider width must be at least one");
	end

	logic [width-1:0] count_q;

	// counts modulo bus clocks then pulses; held at zero while stopped
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count_q <= '0;
		end else if (!run) begin
			count_q <= '0;
		end else if (count_q >= modulo - width'(1)) begin
			count_q <= '0;
		end else begin
			count_q <= count_q + width'(1);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tick <= 1'b0;
		end else begin
			tick <= run && (count_q >= modulo - width'(1));
		end
	end
endmodule
`default_nettype wire

/* baud_rate_gen.sv */
/*
 baud_rate_gen: baud rate generator of one serial interface, apb slave.
 assumes break and edge flag events arrive as one-cycle pulses from the
 receiver, synchronous to pclk.
*/
`timescale 1ns/100ps
`default_nettype none
module baud_rate_gen
	import baud_gen_pkg::*;
#(
	parameter int unsigned div_bits = div_width
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic break_detect_event,
	input wire logic rx_edge_event,
	output logic sample_tick,
	output logic baud_tick,
	output logic receiver_enable,
	output logic transmitter_enable,
	output logic irq
);
	if (div_bits != div_width) begin : width_check
		$error("divisor width is fixed by the register layout");
	end
	if (div_high_width >= div_width) begin : half_check
		$error("high divisor half wider than the divisor");
	end
	if (high_div_msb + 1 != div_high_width) begin : field_check
		$error("high divisor field must sit at bit zero");
	end
	if (unused_high_bit != high_div_msb + 1) begin : spare_check
		$error("spare bit must sit just above the divisor field");
	end
	if (break_irq_en_bit == edge_irq_en_bit) begin : enable_check
		$error("the two interrupt enables need their own bits");
	end
	if (oversample != (1 << os_width)) begin : wrap_check
		$error("oversample count must wrap at its own width");
	end
	if (low_reset == '0) begin : reset_check
		$error("low divisor must leave reset non-zero");
	end
	if (re_bit == te_bit) begin : ctrl_check
		$error("receiver and transmitter enables need own bits");
	end
	if (st_break_bit == st_edge_bit) begin : flag_check
		$error("break and edge flags need their own status bits");
	end
	if (st_tick_bit >= st_width) begin : tick_check
		$error("tick flag must sit inside the status word");
	end


	localparam logic [os_width-1:0] os_last = os_width'(oversample - 1);

	high_fields_t high_q;
	logic [div_high_width-1:0] high_buf_q;
	logic [7:0] low_q;
	enables_t en_q;
	logic [st_width-1:0] status_q;
	logic [st_width-1:0] mask_q;
	logic [st_width-1:0] events;
	gen_state_t state_q;
	logic [div_width-1:0] baud_divisor;
	logic [os_width-1:0] os_q;
	logic wr;
	logic rd_err;
	logic gen_run_w;
	logic tick;
	logic [7:0] high_rd;
	logic wr_high;
	logic wr_low;
	logic wr_ctrl;
	logic wr_status;
	logic wr_mask;
	logic [st_width-1:0] irq_en;
	logic [31:0] ctrl_rd;
	logic [31:0] gen_rd;

	assign wr = psel && penable && pwrite;
	assign pready = 1'b1;
	assign baud_divisor = {high_q.div_high, low_q};
	assign receiver_enable = en_q.receiver_enable;
	assign transmitter_enable = en_q.transmitter_enable;

	// bit 5 never stored, so it reads zero
	assign high_rd = {high_q.break_detect_irq_enable,
		high_q.rx_edge_irq_enable, 1'b0, high_buf_q};

	// one decode for all writes; the gen status word is read-only
	always_comb begin
		wr_high = 1'b0;
		wr_low = 1'b0;
		wr_ctrl = 1'b0;
		wr_status = 1'b0;
		wr_mask = 1'b0;
		if (wr) begin
			case (paddr)
				baud_divisor_high_reg_off: wr_high = 1'b1;
				baud_divisor_low_reg_off: wr_low = 1'b1;
				control_two_reg_off: wr_ctrl = 1'b1;
				irq_status_off: wr_status = 1'b1;
				irq_mask_off: wr_mask = 1'b1;
				default: begin
				end
			endcase
		end
	end

	// buffered upper half; the working copy moves only on a low write
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			high_buf_q <= high_reset[high_div_msb:0];
		end else if (wr_high) begin
			high_buf_q <= pwdata[high_div_msb:0];
		end
	end

	// interrupt enables take effect at once, unlike the divisor half
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			high_q <= '0;
		end else begin
			if (wr_high) begin
				high_q.break_detect_irq_enable <=
					pwdata[break_irq_en_bit];
				high_q.rx_edge_irq_enable <=
					pwdata[edge_irq_en_bit];
			end
			if (wr_low) begin
				high_q.div_high <= high_buf_q;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			low_q <= low_reset;
		end else if (wr_low) begin
			low_q <= pwdata[7:0];
		end
	end

	// clearing both enables leaves the generator running
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			en_q <= '0;
		end else if (wr_ctrl) begin
			en_q.receiver_enable <= pwdata[re_bit];
			en_q.transmitter_enable <= pwdata[te_bit];
		end
	end

	// generator state: idle until first enable, off while divisor is zero
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= gen_idle;
		end else begin
			case (state_q)
				gen_idle: begin
					if (en_q.receiver_enable || en_q.transmitter_enable) begin
						state_q <= (baud_divisor == '0) ? gen_off : gen_run;
					end
				end
				gen_run: begin
					if (baud_divisor == '0) begin
						state_q <= gen_off;
					end
				end
				gen_off: begin
					if (baud_divisor != '0) begin
						state_q <= gen_run;
					end
				end
				default: begin
					state_q <= gen_idle;
				end
			endcase
		end
	end

	// zero divisor also gates the counter in the switching cycle
	assign gen_run_w = (state_q == gen_run) && (baud_divisor != '0);

	// one divider per instance drives both directions
	baud_divider #(
		.width(div_width)
	) u_div (
		.pclk(pclk),
		.presetn(presetn),
		.run(gen_run_w),
		.modulo(baud_divisor),
		.tick(tick)
	);

	assign sample_tick = tick;

	// sixteen sample ticks make one bit time
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			os_q <= '0;
		end else if (!gen_run_w) begin
			os_q <= '0;
		end else if (tick) begin
			os_q <= (os_q == os_last) ? '0 : os_q + os_width'(1);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			baud_tick <= 1'b0;
		end else begin
			baud_tick <= tick && (os_q == os_last);
		end
	end

	assign events = {baud_tick, rx_edge_event, break_detect_event};

	// sticky flags, write one to clear; a new event beats the clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			status_q <= '0;
		end else if (wr_status) begin
			status_q <= (status_q & ~pwdata[st_width-1:0]) | events;
		end else begin
			status_q <= status_q | events;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mask_q <= mask_reset;
		end else if (wr_mask) begin
			mask_q <= pwdata[st_width-1:0];
		end
	end

	// break and edge need both their high-register enable and mask bit
	always_comb begin
		irq_en = mask_q;
		irq_en[st_break_bit] = mask_q[st_break_bit] &&
			high_q.break_detect_irq_enable;
		irq_en[st_edge_bit] = mask_q[st_edge_bit] &&
			high_q.rx_edge_irq_enable;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq <= 1'b0;
		end else begin
			irq <= |(status_q & irq_en);
		end
	end

	always_comb begin
		ctrl_rd = '0;
		ctrl_rd[re_bit] = en_q.receiver_enable;
		ctrl_rd[te_bit] = en_q.transmitter_enable;
	end

	always_comb begin
		gen_rd = '0;
		gen_rd[gs_active_bit] = gen_run_w;
	end

	always_comb begin
		rd_err = 1'b0;
		case (paddr)
			baud_divisor_high_reg_off: prdata = {24'h000000, high_rd};
			baud_divisor_low_reg_off: prdata = {24'h000000, low_q};
			control_two_reg_off: prdata = ctrl_rd;
			irq_status_off: prdata = {29'h00000000, status_q};
			irq_mask_off: prdata = {29'h00000000, mask_q};
			gen_status_off: prdata = gen_rd;
			default: begin
				prdata = '0;
				rd_err = 1'b1;
			end
		endcase
	end

	assign pslverr = psel && penable && rd_err;
endmodule
`default_nettype wire

/* rx_event_model.sv */
/*
 far side stand-in: receiver flag events as one-cycle pulses.
 assumes requests from the bench, synchronous to pclk.
*/
`timescale 1ns/100ps
`default_nettype none
module rx_event_model (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic brk_req,
	input wire logic edg_req,
	output logic break_detect_event,
	output logic rx_edge_event
);
	// registered, so a pulse never races the bench edge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			break_detect_event <= 1'b0;
			rx_edge_event <= 1'b0;
		end else begin
			break_detect_event <= brk_req;
			rx_edge_event <= edg_req;
		end
	end
endmodule
`default_nettype wire

/* baud_rate_gen_monitor.sv */
/*
 port monitor of the baud generator.
 assumes the register map of baud_gen_pkg.
*/
`timescale 1ns/100ps
`default_nettype none
module baud_rate_gen_monitor
	import baud_gen_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic break_detect_event,
	input wire logic rx_edge_event,
	input wire logic sample_tick,
	input wire logic baud_tick,
	input wire logic irq
);
	wire logic wr = psel & penable & pwrite;
	wire logic rd = psel & penable & !pwrite;
	logic [4:0] hb_q, gap_q, stab_q, cnt_q;
	logic [1:0] ie_q, msk_q;
	logic [7:0] lo_q;
	logic [12:0] div_q;
	logic en_q, seen_q;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			{ie_q, hb_q, msk_q, en_q} <= 10'h000;
			lo_q <= low_reset;
			div_q <= {5'h00, low_reset};
		end else if (wr) begin
			if (paddr == baud_divisor_high_reg_off)
				{ie_q, hb_q} <= {pwdata[7:6], pwdata[4:0]};
			if (paddr == baud_divisor_low_reg_off)
				{div_q, lo_q} <= {hb_q, pwdata[7:0], pwdata[7:0]};
			if (paddr == irq_mask_off)
				msk_q <= pwdata[1:0];
			if (paddr == control_two_reg_off && pwdata[3:2] != 2'h0)
				en_q <= 1'b1;
		end
	end
	// saturating counters keep long spans out of repetitions
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			{gap_q, stab_q, cnt_q, seen_q} <= 16'h0000;
		end else begin
			gap_q <= sample_tick ? 5'h00 : gap_q + {4'h0, gap_q != 5'h1f};
			stab_q <= (wr && paddr == baud_divisor_low_reg_off) ? 5'h00
				: stab_q + {4'h0, stab_q != 5'h1f};
			if (baud_tick || div_q == 13'h0000) begin
				cnt_q <= 5'h00;
				seen_q <= baud_tick;
			end else if (sample_tick)
				cnt_q <= cnt_q + 5'h01;
		end
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_brk; break_detect_event && ie_q[1] && msk_q[0]; endsequence
	sequence s_edg; rx_edge_event && ie_q[0] && msk_q[1]; endsequence
	property p_idle; !en_q |-> !sample_tick && !baud_tick; endproperty
	property p_off; (div_q == 13'h0000) [*3] |-> !sample_tick; endproperty
	property p_baud;
		baud_tick && seen_q |-> cnt_q + {4'h0, sample_tick} == 5'h10;
	endproperty
	property p_gap;
		sample_tick && stab_q == 5'h1f && gap_q != 5'h1f && div_q < 13'h1f
			|-> gap_q == div_q[4:0] - 5'h01;
	endproperty
	property p_low;
		rd && paddr == baud_divisor_low_reg_off |-> prdata == {24'h0, lo_q};
	endproperty
	property p_high;
		rd && paddr == baud_divisor_high_reg_off
			|-> prdata == {24'h0, ie_q, 1'b0, hb_q};
	endproperty
	property p_brk; s_brk |-> ##[1:2] irq; endproperty
	property p_edg; s_edg |-> ##[1:2] irq; endproperty
	a_idle: assert property (p_idle) else $error("tick while idle");
	a_off: assert property (p_off) else $error("tick at zero");
	a_baud: assert property (p_baud) else $error("baud count");
	a_low: assert property (p_low) else $error("low read");
	a_brk: assert property (p_brk) else $error("no break irq");
	a_edg: assert property (p_edg) else $error("no edge irq");
	a_gap: assert property (p_gap) else $error("tick spacing");
	a_high: assert property (p_high) else $error("high read");
endmodule
bind baud_rate_gen baud_rate_gen_monitor mon (.pclk, .presetn, .psel,
	.penable, .pwrite, .paddr, .pwdata, .prdata, .break_detect_event,
	.rx_edge_event, .sample_tick, .baud_tick, .irq);
`default_nettype wire

/* baud_rate_gen_tb.sv */
/*
 bench of the baud generator: apb tasks, reference values, verdict.
 assumes baud_gen_pkg and the receiver event model.
*/
`timescale 1ns/100ps
`default_nettype none
module baud_rate_gen_tb
	import baud_gen_pkg::*;
;
	localparam logic [7:0] a_hi = baud_divisor_high_reg_off;
	localparam logic [7:0] a_lo = baud_divisor_low_reg_off;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, se;
	logic sample_tick, baud_tick, receiver_enable, transmitter_enable;
	logic break_detect_event, rx_edge_event, brk_req, edg_req;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rv, seed;
	int errors, n_checks, g, d, m_hb, m_div;
	baud_rate_gen uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .break_detect_event,
		.rx_edge_event, .sample_tick, .baud_tick, .receiver_enable,
		.transmitter_enable, .irq);
	rx_event_model far (.pclk, .presetn, .brk_req, .edg_req,
		.break_detect_event, .rx_edge_event);
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input int wd);
		@(posedge pclk);
		{psel, pwrite, paddr, pwdata} <= {1'b1, w, a, wd};
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rv = prdata;
		se = pslverr;
		// model: high half buffered, taken whole at the low write
		if (w && a == a_hi)
			m_hb = wd[4:0];
		if (w && a == a_lo)
			m_div = (m_hb << 8) | wd[7:0];
		{psel, penable} <= 2'b00;
	endtask
	// waits on sample or baud tick, then counts the period
	task automatic gap(input logic b);
		g = 0;
		@(posedge pclk);
		while ((b ? baud_tick : sample_tick) !== 1'b1) @(posedge pclk);
		do begin
			@(posedge pclk);
			g++;
		end while ((b ? baud_tick : sample_tick) !== 1'b1);
	endtask
	task automatic quiet;
		g = 0;
		repeat (60) begin
			@(posedge pclk);
			g += (sample_tick !== 1'b0);
		end
	endtask
	task automatic results;
		if (errors == 0 && n_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	initial begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end
	initial begin
		repeat (20000) @(posedge pclk);
		errors++;
		results;
	end
	initial begin
		{presetn, psel, penable, pwrite, brk_req, edg_req} = 6'h00;
		{paddr, pwdata, errors, n_checks} = '0;
		seed = 32'hbd731e1a;
		m_hb = 0;
		m_div = int'(low_reset);
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		apb(0, a_lo, 0);
		chk(rv, {24'h000000, low_reset});
		chk(se, 0);
		apb(0, 8'h20, 0);
		chk(rv, 0);
		chk(se, 1);
		quiet;
		chk(g, 0);
		apb(1, a_hi, 32'hff);
		apb(0, a_hi, 0);
		chk(rv, 32'hdf);
		apb(0, gen_status_off, 0);
		chk(rv, 0);
		apb(1, control_two_reg_off, 32'hc);
		@(posedge pclk);
		chk({receiver_enable, transmitter_enable}, 2'b11);
		gap(0);
		gap(0);
		chk(g, m_div);
		apb(0, gen_status_off, 0);
		chk(rv, 32'h1 << gs_active_bit);
		apb(1, a_hi, 32'hc0);
		repeat (3) begin
			seed = lfsr(seed);
			d = seed[2:0] + 2;
			apb(1, a_lo, d);
			gap(0);
			gap(0);
			chk(g, m_div);
			gap(1);
			gap(1);
			chk(g, oversample * m_div);
		end
		apb(1, a_hi, 32'hc1);
		apb(1, a_lo, 0);
		gap(0);
		gap(0);
		chk(g, m_div);
		apb(1, a_hi, 32'hc0);
		apb(1, a_lo, 0);
		repeat (3) @(posedge pclk);
		quiet;
		chk(g, 0);
		apb(0, gen_status_off, 0);
		chk(rv, 0);
		apb(1, irq_mask_off, 32'h3);
		for (int i = 0; i < 2; i++) begin
			apb(1, irq_status_off, 32'h7);
			apb(1, a_hi, 32'h40 << i);
			{brk_req, edg_req} <= 2'b01 << i;
			@(posedge pclk);
			{brk_req, edg_req} <= 2'b00;
			repeat (4) @(posedge pclk);
			chk(irq, 1);
			apb(1, a_hi, 32'h80 >> i);
			repeat (3) @(posedge pclk);
			chk(irq, 0);
			apb(0, irq_status_off, 0);
			chk(rv[1:0], 2'b10 >> i);
		end
		results;
	end
endmodule
`default_nettype wire
